/* File: pkg/mrd_pkg.sv */
package mrd_pkg;
   // array addressing
   localparam int ADDR_W = 24;
   localparam logic [23:0] ARRAY_TOP_DEF = 24'hFFFFFF;
   // read opcodes
   localparam logic [7:0] OP_FAST_READ = 8'h0B;
   localparam logic [7:0] OP_DUAL_OUTPUT_READ = 8'h3B;
   localparam logic [7:0] OP_DUAL_ADDR_DATA_READ = 8'hBB;
   localparam logic [7:0] OP_QUAD_OUTPUT_READ = 8'h6B;
   localparam logic [7:0] OP_QUAD_ADDR_DATA_READ = 8'hEB;
   localparam logic [7:0] OP_QUAD_READ_SHORT_DUMMY = 8'hE7;
   // configuration register dummy-select field positions
   localparam int DUMMY_SELECT_LOW_POS = 6;
   localparam int DUMMY_SELECT_HIGH_POS = 7;
   // lane widths
   localparam logic [2:0] LANES_1 = 3'h1;
   localparam logic [2:0] LANES_2 = 3'h2;
   localparam logic [2:0] LANES_4 = 3'h4;
   // serial clock counts
   localparam logic [4:0] CMD_CLKS_SPI = 5'h08;
   localparam logic [4:0] CMD_CLKS_QUAD = 5'h02;
   localparam logic [4:0] ADDR_CLKS_1 = 5'h18;
   localparam logic [4:0] ADDR_CLKS_2 = 5'h0C;
   localparam logic [4:0] ADDR_CLKS_4 = 5'h06;
   localparam logic [3:0] EXIT_ONES_CLKS = 4'h8;
   localparam logic [3:0] EXIT_BROKEN = 4'hF;
   localparam logic [3:0] SHORT_DUMMY_CLKS = 4'h4;
   // dummy clocks indexed by the dummy-select field
   localparam logic [3:0] DUMMY_OUT_TBL [0:3] = '{4'h8, 4'h6, 4'h8, 4'hA};
   localparam logic [3:0] DUMMY_DUAL_IO_TBL [0:3] =
      '{4'h4, 4'h6, 4'h8, 4'hA};
   localparam logic [3:0] DUMMY_QUAD_IO_TBL [0:3] =
      '{4'h6, 4'h4, 4'h8, 4'hA};

   // decoded read form
   typedef struct packed {
      logic valid;
      logic [2:0] addr_w;
      logic [2:0] data_w;
      logic [3:0] dummy;
      logic indicator;
   } mrd_form_type;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CMD,
      ST_ADDR,
      ST_DUMMY,
      ST_DATA,
      ST_IGNORE
   } mrd_state_type;
endpackage : mrd_pkg

/* File: hdl/mrd_read_engine.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - fast read: opcode, 3-byte address on rising edges, dummies, 1 bit/fall
// - address counter advances on the first fall of every data byte, as that byte is loaded
// - address past the top of the array wraps to zero, data continues
// - chip select high anytime ends the command and stops data drive
// - reads are ignored while an internal write cycle is busy
// - dual output read: address and dummies on line 0, 2 bits per fall
// - dual address/data read: address 2 bits per clock, 4 default dummies
// - quad output read: address on line 0, 8 dummies, 4 bits per fall
// - quad address/data read: address 4 bits per clock, 6 dummies
// - same quad address/data read accepted in quad command mode
// - opcode E7h is quad address/data read with 4 dummies, spi only
// - indicator nibbles complementing each other keep continuous-read mode
// - non-complementing indicator ends continuous mode after select cycles
// - dummy counts come from configuration bits 6 and 7, except the fixed 4 of E7h
// - any array byte is a legal start address
// - in continuous mode the first clocks after select are address bits
// - eight all-ones clocks on line 0 force exit from continuous mode
module mrd_read_engine #(
   parameter logic [23:0] ARRAY_TOP = mrd_pkg::ARRAY_TOP_DEF
) (
   input wire logic clk_in, // system clock
   input wire logic srst_in, // synchronous reset, active high
   input wire logic sclk_in, // serial clock from host
   input wire logic cs_n_in, // chip select, active low
   input wire logic [3:0] io_in, // io_line_3..io_line_0 pin levels
   output logic [3:0] io_out, // io line output values
   output logic [3:0] io_oe_out, // io line output enables
   input wire logic quad_enable_bit_in, // quad enable status bit
   input wire logic quad_command_mode_in, // quad command mode active
   input wire logic [7:0] config_reg_in, // configuration register
   input wire logic write_busy_in, // program/erase/status write busy
   input wire logic [7:0] mem_data_in, // array byte at mem_addr_out
   output logic [23:0] mem_addr_out, // array read address
   output logic cont_mode_out // continuous-read mode active
);
   // pin synchronisers: {cs, sclk, io[3:0]}
   logic [5:0] pin_s1_r;
   logic [5:0] pin_s2_r;
   logic [5:0] pin_s3_r;
   logic [5:0] pin_lvl_r;
   logic [5:0] pin_lvl_nxt;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_rise;
   logic cs_fall;
   logic cs_high;
   logic [3:0] io_now;

   mrd_pkg::mrd_state_type state_r;
   mrd_pkg::mrd_form_type form_r;
   mrd_pkg::mrd_form_type cont_form_r;
   mrd_pkg::mrd_form_type op_form;
   logic [4:0] cnt_r;
   logic [7:0] cmd_r;
   logic [7:0] cmd_nxt;
   logic [23:0] addr_r;
   logic [23:0] addr_inc;
   logic [2:0] bit_r;
   logic [3:0] ind_hi_r;
   logic cont_r;
   logic cont_acc_r;
   logic [3:0] ones_cnt_r;
   logic [7:0] sh_r;
   logic [7:0] cur_byte;
   logic [3:0] io_r;
   logic [3:0] oe_r;
   logic [1:0] dsel;

   // shift w bits of the io lines into the low end of a value
   function automatic logic [23:0] shift_in(input logic [23:0] v,
                                            input logic [3:0] io,
                                            input logic [2:0] w);
      logic [23:0] r;
      r = {v[22:0], io[0]};
      if (w == mrd_pkg::LANES_2) begin
         r = {v[21:0], io[1:0]};
      end else if (w == mrd_pkg::LANES_4) begin
         r = {v[19:0], io[3:0]};
      end
      return r;
   endfunction : shift_in

   // rising-edge count of the address phase for a lane width
   function automatic logic [4:0] addr_clks(input logic [2:0] w);
      logic [4:0] r;
      r = mrd_pkg::ADDR_CLKS_1;
      if (w == mrd_pkg::LANES_2) begin
         r = mrd_pkg::ADDR_CLKS_2;
      end else if (w == mrd_pkg::LANES_4) begin
         r = mrd_pkg::ADDR_CLKS_4;
      end
      return r;
   endfunction : addr_clks

   // opcode decode into a read form; invalid forms are ignored
   function automatic mrd_pkg::mrd_form_type decode(input logic [7:0] op,
                                                    input logic quad_cmd,
                                                    input logic qe,
                                                    input logic [1:0] ds);
      mrd_pkg::mrd_form_type f;
      f = '0;
      if (quad_cmd) begin
         if (op == mrd_pkg::OP_QUAD_ADDR_DATA_READ) begin
            f = '{1'b1, mrd_pkg::LANES_4, mrd_pkg::LANES_4,
                  mrd_pkg::DUMMY_QUAD_IO_TBL[ds], 1'b1};
         end
      end else if (op == mrd_pkg::OP_FAST_READ) begin
         f = '{1'b1, mrd_pkg::LANES_1, mrd_pkg::LANES_1,
               mrd_pkg::DUMMY_OUT_TBL[ds], 1'b0};
      end else if (op == mrd_pkg::OP_DUAL_OUTPUT_READ) begin
         f = '{1'b1, mrd_pkg::LANES_1, mrd_pkg::LANES_2,
               mrd_pkg::DUMMY_OUT_TBL[ds], 1'b0};
      end else if (op == mrd_pkg::OP_DUAL_ADDR_DATA_READ) begin
         f = '{1'b1, mrd_pkg::LANES_2, mrd_pkg::LANES_2,
               mrd_pkg::DUMMY_DUAL_IO_TBL[ds], 1'b0};
      end else if (op == mrd_pkg::OP_QUAD_OUTPUT_READ) begin
         f = '{qe, mrd_pkg::LANES_1, mrd_pkg::LANES_4,
               mrd_pkg::DUMMY_OUT_TBL[ds], 1'b0};
      end else if (op == mrd_pkg::OP_QUAD_ADDR_DATA_READ) begin
         f = '{qe, mrd_pkg::LANES_4, mrd_pkg::LANES_4,
               mrd_pkg::DUMMY_QUAD_IO_TBL[ds], 1'b1};
      end else if (op == mrd_pkg::OP_QUAD_READ_SHORT_DUMMY) begin
         f = '{qe, mrd_pkg::LANES_4, mrd_pkg::LANES_4,
               mrd_pkg::SHORT_DUMMY_CLKS, 1'b1};
      end
      return f;
   endfunction : decode

   // three-stage pin synchroniser
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         pin_s1_r <= 6'h20;
         pin_s2_r <= 6'h20;
         pin_s3_r <= 6'h20;
         pin_lvl_r <= 6'h20;
      end else begin
         pin_s1_r <= {cs_n_in, sclk_in, io_in};
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         pin_lvl_r <= pin_lvl_nxt;
      end
   end

   // a level counts once stages two and three agree
   assign pin_lvl_nxt = (pin_s3_r & ~(pin_s2_r ^ pin_s3_r)) |
                        (pin_lvl_r & (pin_s2_r ^ pin_s3_r));
   assign cs_high = pin_lvl_nxt[5];
   assign cs_rise = pin_lvl_nxt[5] & ~pin_lvl_r[5];
   assign cs_fall = ~pin_lvl_nxt[5] & pin_lvl_r[5];
   assign sclk_rise = pin_lvl_nxt[4] & ~pin_lvl_r[4];
   assign sclk_fall = ~pin_lvl_nxt[4] & pin_lvl_r[4];
   assign io_now = pin_lvl_nxt[3:0];

   // decode helpers
   assign dsel = {config_reg_in[mrd_pkg::DUMMY_SELECT_HIGH_POS],
                  config_reg_in[mrd_pkg::DUMMY_SELECT_LOW_POS]};
   assign cmd_nxt = quad_command_mode_in ? {cmd_r[3:0], io_now}
                                         : {cmd_r[6:0], io_now[0]};
   assign op_form = decode(cmd_nxt, quad_command_mode_in,
                           quad_enable_bit_in, dsel);
   assign addr_inc = (addr_r == ARRAY_TOP) ? 24'h000000
                                           : addr_r + 24'h000001;
   assign cur_byte = (bit_r == 3'h0) ? mem_data_in : sh_r;

   // command sequencer, address counter and byte position
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         state_r <= mrd_pkg::ST_IDLE;
         form_r <= '0;
         cnt_r <= 5'h00;
         cmd_r <= 8'h00;
         addr_r <= 24'h000000;
         bit_r <= 3'h0;
         ind_hi_r <= 4'h0;
      end else if (cs_high) begin
         state_r <= mrd_pkg::ST_IDLE;
      end else if (cs_fall) begin
         cnt_r <= 5'h00;
         cmd_r <= 8'h00;
         bit_r <= 3'h0;
         if (cont_r) begin
            form_r <= cont_form_r;
            state_r <= write_busy_in ? mrd_pkg::ST_IGNORE
                                     : mrd_pkg::ST_ADDR;
         end else begin
            state_r <= mrd_pkg::ST_CMD;
         end
      end else if (sclk_rise) begin
         case (state_r)
            mrd_pkg::ST_CMD: begin
               cmd_r <= cmd_nxt;
               cnt_r <= cnt_r + 5'h01;
               if (cnt_r == (quad_command_mode_in ? mrd_pkg::CMD_CLKS_QUAD
                             : mrd_pkg::CMD_CLKS_SPI) - 5'h01) begin
                  cnt_r <= 5'h00;
                  form_r <= op_form;
                  if (!op_form.valid || write_busy_in) begin
                     state_r <= mrd_pkg::ST_IGNORE;
                  end else begin
                     state_r <= mrd_pkg::ST_ADDR;
                  end
               end
            end
            mrd_pkg::ST_ADDR: begin
               addr_r <= shift_in(addr_r, io_now, form_r.addr_w);
               cnt_r <= cnt_r + 5'h01;
               if (cnt_r == addr_clks(form_r.addr_w) - 5'h01) begin
                  cnt_r <= 5'h00;
                  state_r <= mrd_pkg::ST_DUMMY;
               end
            end
            mrd_pkg::ST_DUMMY: begin
               cnt_r <= cnt_r + 5'h01;
               if (form_r.indicator && cnt_r == 5'h00) begin
                  ind_hi_r <= io_now;
               end
               if (cnt_r == {1'b0, form_r.dummy} - 5'h01) begin
                  cnt_r <= 5'h00;
                  bit_r <= 3'h0;
                  state_r <= mrd_pkg::ST_DATA;
               end
            end
            default: begin
               state_r <= state_r;
            end
         endcase
      end else if (sclk_fall && state_r == mrd_pkg::ST_DATA) begin
         bit_r <= bit_r + form_r.data_w;
         if (bit_r == 3'h0) begin
            addr_r <= addr_inc;
         end
      end
   end

   // continuous-read mode flag and forced exit detection
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         cont_r <= 1'b0;
         cont_form_r <= '0;
         cont_acc_r <= 1'b0;
         ones_cnt_r <= 4'h0;
      end else if (cs_rise) begin
         cont_acc_r <= 1'b0;
         if (cont_acc_r && ones_cnt_r == mrd_pkg::EXIT_ONES_CLKS) begin
            cont_r <= 1'b0;
         end
      end else if (cs_fall) begin
         cont_acc_r <= cont_r;
         ones_cnt_r <= 4'h0;
      end else if (sclk_rise) begin
         if (cont_acc_r && ones_cnt_r < mrd_pkg::EXIT_ONES_CLKS) begin
            ones_cnt_r <= io_now[0] ? ones_cnt_r + 4'h1
                                    : mrd_pkg::EXIT_BROKEN;
         end
         if (state_r == mrd_pkg::ST_DUMMY && form_r.indicator &&
             cnt_r == 5'h01) begin
            cont_r <= (ind_hi_r == ~io_now);
            cont_form_r <= form_r;
         end
      end
   end

   // data shifter: new bits on each falling edge of the data phase
   always_ff @(posedge clk_in) begin
      if (srst_in || cs_high) begin
         sh_r <= 8'h00;
         io_r <= 4'h0;
         oe_r <= 4'h0;
      end else if (state_r != mrd_pkg::ST_DATA) begin
         oe_r <= 4'h0;
      end else if (sclk_fall) begin
         if (form_r.data_w == mrd_pkg::LANES_4) begin
            io_r <= cur_byte[7:4];
            oe_r <= 4'hF;
            sh_r <= {cur_byte[3:0], 4'h0};
         end else if (form_r.data_w == mrd_pkg::LANES_2) begin
            io_r <= {2'b00, cur_byte[7:6]};
            oe_r <= 4'h3;
            sh_r <= {cur_byte[5:0], 2'b00};
         end else begin
            io_r <= {2'b00, cur_byte[7], 1'b0};
            oe_r <= 4'h2;
            sh_r <= {cur_byte[6:0], 1'b0};
         end
      end
   end

   // outputs straight from flip-flops
   assign io_out = io_r;
   assign io_oe_out = oe_r;
   assign mem_addr_out = addr_r;
   assign cont_mode_out = cont_r;
endmodule : mrd_read_engine

/* File: tb/mrd_read_engine_asserts.sv */
`timescale 1ns/10ps
module mrd_read_engine_asserts #(
   parameter logic [23:0] ARRAY_TOP = 24'hFFFFFF
) (
   input wire logic clk_in, // system clock
   input wire logic srst_in, // sync reset
   input wire logic sclk_in, // serial clock
   input wire logic cs_n_in, // chip select
   input wire logic [3:0] io_out, // line values
   input wire logic [3:0] io_oe_out, // line enables
   input wire logic quad_enable_bit_in, // quad enable
   input wire logic write_busy_in, // write busy
   input wire logic [23:0] mem_addr_out, // address counter
   input wire logic cont_mode_out // continuous mode
);
   logic busy_sel_r; // busy held since before select fell
   default clocking dcb @(posedge clk_in);
   endclocking
   default disable iff (srst_in);
   // marks frames that began while a write was busy
   always_ff @(posedge clk_in) begin
      if (srst_in) busy_sel_r <= 1'b0;
      else busy_sel_r <= write_busy_in & (cs_n_in | busy_sel_r);
   end
   AST_CS_HIGH_IDLE: assert property (
      cs_n_in [*6] |-> io_oe_out == 4'h0)
      else $error("lines driven while deselected");
   AST_SEL_QUIET: assert property (
      $fell(cs_n_in) |-> (io_oe_out == 4'h0) [*8])
      else $error("lines driven during command");
   AST_BUSY_QUIET: assert property (
      busy_sel_r && !cs_n_in |-> io_oe_out == 4'h0)
      else $error("read answered while busy");
   AST_OE_LANES: assert property (
      io_oe_out inside {4'h0, 4'h2, 4'h3, 4'hF})
      else $error("illegal lane set driven");
   AST_QUAD_NEEDS_QE: assert property (
      io_oe_out == 4'hF |-> quad_enable_bit_in)
      else $error("quad data without quad enable");
   AST_ADDR_STEP: assert property (
      io_oe_out != 4'h0 && $past(io_oe_out) != 4'h0
      && mem_addr_out != $past(mem_addr_out) |-> mem_addr_out ==
      ($past(mem_addr_out) == ARRAY_TOP ? 24'h000000 :
      $past(mem_addr_out) + 24'h000001))
      else $error("address did not step by one");
   AST_OUT_ON_FALL: assert property (
      io_oe_out != 4'h0 && $past(io_oe_out) != 4'h0 && $changed(io_out)
      |-> !$past(sclk_in, 2))
      else $error("data changed away from a fall");
   AST_CONT_NEEDS_QE: assert property (
      $rose(cont_mode_out) |-> quad_enable_bit_in)
      else $error("continuous mode without quad");
endmodule : mrd_read_engine_asserts
bind mrd_read_engine mrd_read_engine_asserts #(.ARRAY_TOP(ARRAY_TOP)) u_chk (
   .clk_in(clk_in), .srst_in(srst_in), .sclk_in(sclk_in),
   .cs_n_in(cs_n_in), .io_out(io_out), .io_oe_out(io_oe_out),
   .quad_enable_bit_in(quad_enable_bit_in),
   .write_busy_in(write_busy_in), .mem_addr_out(mem_addr_out),
   .cont_mode_out(cont_mode_out));

/* File: tb/mrd_host_model.sv */
`timescale 1ns/10ps
module mrd_host_model (
   output logic sclk_out, // serial clock, idle low
   output logic cs_n_out, // chip select
   output logic [3:0] io_out, // driven line values
   output logic [3:0] io_oe_out, // line enables
   input wire logic [3:0] io_in // resolved line levels
);
   logic [7:0] rd [0:7]; // captured data bytes
   // idle link: clock still, select high, lines released
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      io_out = 4'h0;
      io_oe_out = 4'h0;
   end
   // one clock: drive in low phase, hold through the rise
   task automatic tick(input logic [3:0] v, input logic [3:0] oe);
      sclk_out = 1'b0;
      io_out = v;
      io_oe_out = oe;
      #40 sclk_out = 1'b1;
      #40;
   endtask : tick
   // ends a frame with the clock high, then parks it low
   task automatic fin();
      cs_n_out = 1'b1;
      io_oe_out = 4'h0;
      #40 sclk_out = 1'b0;
      #120;
   endtask : fin
   task automatic xfer(input logic [7:0] op, input logic [23:0] a,
      input int aw, input int dw, input int nd, input logic ind_en,
      input logic [7:0] ind, input logic qcmd, input logic skip,
      input int nb);
      logic [23:0] sh;
      logic [7:0] b;
      sh = a;
      b = 8'h00;
      cs_n_out = 1'b0;
      #40;
      if (!skip && qcmd) begin
         tick(op[7:4], 4'hF);
         tick(op[3:0], 4'hF);
      end else if (!skip) begin
         for (int i = 7; i >= 0; i--) tick({3'h0, op[i]}, 4'h1);
      end
      for (int i = 0; i < 24 / aw; i++) begin
         tick(4'(sh[23:20] >> (4 - aw)), 4'((1 << aw) - 1));
         sh = sh << aw;
      end
      // indicator lines driven, never left floating
      for (int i = 0; i < nd; i++) begin
         if (ind_en && i < 2) begin
            tick(i == 0 ? ind[7:4] : ind[3:0], 4'hF);
         end else begin
            tick(4'h0, 4'h0);
         end
      end
      for (int k = 0; k < nb; k++) begin
         for (int j = 0; j < 8 / dw; j++) begin
            tick(4'h0, 4'h0);
            if (dw == 1) b = {b[6:0], io_in[1]};
            else if (dw == 2) b = {b[5:0], io_in[1:0]};
            else b = {b[3:0], io_in};
         end
         rd[k] = b;
      end
      fin();
   endtask : xfer
   // eight all-ones clocks on line 0 leave continuous mode
   task automatic exit_seq();
      cs_n_out = 1'b0;
      #40;
      repeat (8) tick(4'h1, 4'h1);
      fin();
   endtask : exit_seq
endmodule : mrd_host_model

/* File: tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
   localparam logic [23:0] TOP = 24'h0000FF;
   logic clk_in, srst_in, qe, qcmd, busy, sclk, cs_n, cont, cm;
   logic [7:0] cfg, mdata;
   logic [3:0] hio, hoe, dio, doe, wio;
   logic [3:0] last_r = 4'h0;
   logic [23:0] maddr;
   logic [31:0] lfsr;
   int failures, cmp_count, n0;
   int oe_cnt = 0;
   logic [7:0] ops [0:5] = '{8'h0B, 8'h3B, 8'hBB, 8'h6B, 8'hEB, 8'hE7};
   logic [7:0] inds [0:7] = '{8'hA5, 8'hFF, 8'h5A, 8'h00, 8'hF0, 8'hAA,
      8'h0F, 8'h55};
   // undriven lines show the inverse of their last level
   assign wio = (dio & doe) | (hio & hoe & ~doe) | (~last_r & ~doe & ~hoe);
   assign mdata = {maddr[3:0], maddr[7:4]} ^ 8'hC3;
   always @(posedge clk_in) last_r <= wio;
   always @(posedge clk_in) if (doe != 4'h0) oe_cnt <= oe_cnt + 1;
   mrd_read_engine #(.ARRAY_TOP(TOP)) dut (.clk_in(clk_in),
      .srst_in(srst_in), .sclk_in(sclk), .cs_n_in(cs_n), .io_in(wio),
      .io_out(dio), .io_oe_out(doe), .quad_enable_bit_in(qe),
      .quad_command_mode_in(qcmd), .config_reg_in(cfg),
      .write_busy_in(busy), .mem_data_in(mdata), .mem_addr_out(maddr),
      .cont_mode_out(cont));
   mrd_host_model host (.sclk_out(sclk), .cs_n_out(cs_n), .io_out(hio),
      .io_oe_out(hoe), .io_in(wio));
   // expected byte, dummy count and next random address
   function automatic logic [7:0] mem_f(input logic [23:0] x);
      return {x[3:0], x[7:4]} ^ 8'hC3;
   endfunction : mem_f
   function automatic int dums(input logic [7:0] o, input logic [1:0] s);
      if (o == 8'hBB) return mrd_pkg::DUMMY_DUAL_IO_TBL[s];
      if (o == 8'hEB) return mrd_pkg::DUMMY_QUAD_IO_TBL[s];
      if (o == 8'hE7) return 4;
      return mrd_pkg::DUMMY_OUT_TBL[s];
   endfunction : dums
   function automatic logic [23:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return {16'h0000, lfsr[7:0]};
   endfunction : rnd
   task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("unexpected at %0t: byte %h, want %h", $time, g, e);
      end
   endtask : cmp8
   task automatic cmp1(input logic g, input logic e);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("unexpected at %0t: flag %b, want %b", $time, g, e);
      end
   endtask : cmp1
   task automatic stop_test();
      if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : stop_test
   // one read of nb bytes, checked against the array model
   task automatic rd(input logic [7:0] o, input logic [23:0] ad,
      input logic [7:0] ind, input logic sk, input int nb);
      int aw, dw;
      logic [23:0] ea;
      aw = (o == 8'hBB) ? 2 : (o[7:4] == 4'hE) ? 4 : 1;
      dw = (o == 8'h0B) ? 1 : (o == 8'h3B || o == 8'hBB) ? 2 : 4;
      host.xfer(o, ad, aw, dw, dums(o, cfg[7:6]), o[7:4] == 4'hE, ind,
         qcmd, sk, nb);
      for (int k = 0; k < nb; k++) begin
         ea = 24'((int'(ad) + k) % (int'(TOP) + 1));
         cmp8(host.rd[k], mem_f(ea));
      end
   endtask : rd
   // a read that must stay silent
   task automatic refuse(input logic [7:0] o, input logic b,
      input logic q, input logic c);
      busy = b;
      qe = q;
      qcmd = c;
      n0 = oe_cnt;
      #10 host.xfer(o, rnd(), 1, 1, 8, 1'b0, 8'hFF, c, 1'b0, 1);
      cmp1(oe_cnt == n0, 1'b1);
      busy = 1'b0;
      qe = 1'b1;
      qcmd = 1'b0;
   endtask : refuse
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   initial begin
      #800000 failures++;
      stop_test();
   end
   // main sequence
   initial begin
      srst_in = 1'b1;
      {qe, qcmd, busy, cm, cfg} = {4'h8, 8'h00};
      {failures, cmp_count, lfsr} = {32'h0, 32'h0, 32'hFEC0};
      repeat (10) @(posedge clk_in);
      #1 srst_in = 1'b0;
      cmp8({4'h0, doe}, 8'h00);
      cmp1(cont, 1'b0);
      repeat (4) @(posedge clk_in);
      // host link changes stay one step past the clock edge
      #1;
      for (int i = 0; i < 6; i++) begin
         for (int s = 0; s < 4; s++) begin
            cfg = {2'(s), lfsr[13:8]};
            rd(ops[i], rnd(), 8'hFF, 1'b0, 3);
         end
      end
      cfg = 8'h00;
      rd(8'h0B, TOP - 24'h1, 8'hFF, 1'b0, 3);
      qcmd = 1'b1;
      rd(8'hEB, rnd(), 8'hFF, 1'b0, 2);
      qcmd = 1'b0;
      for (int i = 0; i < 8; i++) begin
         rd(8'hEB, rnd(), inds[i], cm, 1);
         cm = (inds[i][7:4] == ~inds[i][3:0]);
         cmp1(cont, cm);
      end
      rd(8'hEB, rnd(), 8'h5A, 1'b0, 1);
      host.exit_seq();
      cmp1(cont, 1'b0);
      rd(8'h0B, rnd(), 8'hFF, 1'b0, 2);
      refuse(8'h0B, 1'b1, 1'b1, 1'b0);
      refuse(8'h6B, 1'b0, 1'b0, 1'b0);
      refuse(8'hE7, 1'b0, 1'b1, 1'b1);
      stop_test();
   end
endmodule : testbench
